// >>> core/chop_current_detect_config.sv
`timescale 1ns/100ps
// Contract
// - Bits 12:9 pick a settling delay of two to the (code plus one) modulator clocks, 2 to 65536.
// - After reset the delay field holds 0011b, a delay of 16 modulator clocks.
// - Bit 8 turns global chop on and resets to zero, off.
// - Bit 0 enables current detect (reset off); bit 7 asks for any channel (0) or all (1).
// - Bits 6:4 set the exceedances needed for a detection as two to the code, 1 to 128.
// - Bits 3:1 set the window to 128, 256, 512, 768, 1280, 1792, 2560 or 3584 conversions.
// - The 24-bit signed threshold is bits 23:8 in the upper register and 7:0 in the lower.
module chop_current_detect_config #(
    parameter int NCH = 8
) (
    // Clock, reset, enable
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [31:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Conversion results and chop start
    input  wire logic              conv_valid_i,
    input  wire logic [NCH*24-1:0] conv_data_i,
    input  wire logic              chop_start_i,
    // Status outputs
    output logic                   global_chop_on_o,
    output logic                   chop_settled_o,
    output logic                   detect_flag_o,
    output logic                   detect_pulse_o
);

    typedef struct packed {
        logic [15:0]                   cfg;
        logic [15:0]                   th_up;
        logic [15:0]                   th_lo;
        logic                          ack;
        logic [31:0]                   dat;
        logic                          gc_on;
        logic [ccd_pkg::WIN_CNT_W-1:0] win_cnt;
        logic [ccd_pkg::EXC_CNT_W:0]   exc_cnt;
        logic                          detected;
        logic                          pulse;
    } ccd_state_t;

    ccd_state_t s_r;
    ccd_state_t s_nxt;
    logic       settled;

    // Field views of the configuration word and the threshold registers
    logic [3:0] chop_settle_delay_sel;
    logic       global_chop_on;
    logic       detect_require_every_channel;
    logic [2:0] detect_exceed_count_sel;
    logic [2:0] detect_window_length_sel;
    logic       detect_mode_on;
    logic [23:0] detect_threshold;

    assign chop_settle_delay_sel        = s_r.cfg[ccd_pkg::DLY_MSB:ccd_pkg::DLY_LSB];
    assign global_chop_on               = s_r.cfg[ccd_pkg::GC_BIT];
    assign detect_require_every_channel = s_r.cfg[ccd_pkg::ALL_BIT];
    assign detect_exceed_count_sel      = s_r.cfg[ccd_pkg::NUM_MSB:ccd_pkg::NUM_LSB];
    assign detect_window_length_sel     = s_r.cfg[ccd_pkg::LEN_MSB:ccd_pkg::LEN_LSB];
    assign detect_mode_on               = s_r.cfg[ccd_pkg::EN_BIT];
    assign detect_threshold             = {s_r.th_up, s_r.th_lo[15:8]};

    // Per-channel comparison against the signed threshold
    logic [NCH-1:0] over;
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            over[c] = $signed(conv_data_i[c*24 +: 24]) > $signed(detect_threshold);
        end
    end

    logic req;
    logic [7:0] idx;
    logic hit;
    logic win_end;
    logic [15:0] bmask;
    assign req   = wb_cyc_i && wb_stb_i;
    assign idx   = wb_adr_i[9:2];
    assign bmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign hit   = detect_require_every_channel ? &over : |over;
    // A shorter window written mid-window ends at the next conversion instead of wrapping
    assign win_end = s_r.win_cnt >=
        ccd_pkg::WIN_CNT_W'(ccd_pkg::window_len(detect_window_length_sel) - 13'h0001);

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [15:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction : merge

    always_comb begin
        s_nxt       = s_r;
        s_nxt.pulse = 1'b0;
        s_nxt.gc_on = global_chop_on;

        // Answer one cycle after the request; the write lands on the acked edge
        s_nxt.ack = req && !s_r.ack;
        if (req && !s_r.ack) begin
            case (idx)
                ccd_pkg::CFG_IDX:    s_nxt.dat = {16'h0000, s_r.cfg};
                ccd_pkg::TH_UP_IDX:  s_nxt.dat = {16'h0000, s_r.th_up};
                ccd_pkg::TH_LO_IDX:  s_nxt.dat = {16'h0000, s_r.th_lo};
                ccd_pkg::STATUS_IDX: s_nxt.dat = {30'h0, settled, s_r.detected};
                default:             s_nxt.dat = 32'h00000000;
            endcase
        end

        // Detection counting
        if (!detect_mode_on) begin
            s_nxt.win_cnt = '0;
            s_nxt.exc_cnt = '0;
        end else if (conv_valid_i) begin
            if (win_end) begin
                s_nxt.win_cnt = '0;
                s_nxt.exc_cnt = '0;
            end else begin
                s_nxt.win_cnt = s_r.win_cnt + 12'h001;
            end
            if (hit && s_r.exc_cnt < ccd_pkg::exceed_needed(detect_exceed_count_sel)) begin
                if (!win_end) begin
                    s_nxt.exc_cnt = s_r.exc_cnt + 9'h001;
                end
                if (s_r.exc_cnt + 9'h001 == ccd_pkg::exceed_needed(detect_exceed_count_sel))
                begin
                    s_nxt.pulse = 1'b1;
                end
            end
        end

        // Register writes; status bit 0 clears by writing one, a new detection wins
        if (req && s_r.ack && wb_we_i) begin
            case (idx)
                ccd_pkg::CFG_IDX:
                    s_nxt.cfg = merge(s_r.cfg, wb_dat_i[15:0], bmask & ccd_pkg::CFG_WMASK);
                ccd_pkg::TH_UP_IDX:
                    s_nxt.th_up = merge(s_r.th_up, wb_dat_i[15:0], bmask);
                ccd_pkg::TH_LO_IDX:
                    s_nxt.th_lo = merge(s_r.th_lo, wb_dat_i[15:0],
                                        bmask & ccd_pkg::TH_LO_WMASK);
                ccd_pkg::STATUS_IDX:
                    if (wb_sel_i[0] && wb_dat_i[ccd_pkg::STAT_DETECT_BIT]) begin
                        s_nxt.detected = 1'b0;
                    end
                default: ;
            endcase
        end
        if (s_nxt.pulse) begin
            s_nxt.detected = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_r       <= '0;
            s_r.cfg   <= ccd_pkg::CFG_RST;
            s_r.th_up <= ccd_pkg::TH_RST;
            s_r.th_lo <= ccd_pkg::TH_RST;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    chop_settle_timer u_settle (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (global_chop_on),
        .start_i   (chop_start_i),
        .sel_i     (chop_settle_delay_sel),
        .settled_o (settled)
    );

    assign wb_dat_o         = s_r.dat;
    assign wb_ack_o         = s_r.ack;
    assign global_chop_on_o = s_r.gc_on;
    assign chop_settled_o   = settled;
    assign detect_flag_o    = s_r.detected;
    assign detect_pulse_o   = s_r.pulse;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence wb_write_to(logic [7:0] i);
        req && s_r.ack && wb_we_i && ce_i && idx == i;
    endsequence

    a_reset_cfg_value: assert property (
        $fell(rst_i) |-> s_r.cfg == ccd_pkg::CFG_RST && chop_settle_delay_sel == ccd_pkg::DLY_RST)
        else $error("configuration not at its reset value");

    a_chop_follows_bit: assert property (
        ce_i ##1 ce_i |-> global_chop_on_o == $past(global_chop_on))
        else $error("global chop output does not follow its bit");

    a_detect_off_quiet: assert property (
        ce_i && !detect_mode_on |=> !detect_pulse_o && s_r.exc_cnt == '0)
        else $error("detection activity while detect mode is off");

    a_all_channels_need: assert property (
        ce_i && detect_mode_on && detect_require_every_channel && conv_valid_i && !(&over)
        && !win_end |=> s_r.exc_cnt == $past(s_r.exc_cnt))
        else $error("count moved without every channel over threshold");

    a_pulse_at_count: assert property (
        detect_pulse_o |-> $past(s_r.exc_cnt) + 9'h001
                           == ccd_pkg::exceed_needed($past(detect_exceed_count_sel)))
        else $error("detection raised at the wrong exceedance count");

    a_window_bound: assert property (
        ce_i && detect_mode_on && conv_valid_i
        |=> {1'b0, s_r.win_cnt} < ccd_pkg::window_len($past(detect_window_length_sel)))
        else $error("window counter ran past the window length");

    a_thresh_lower_split: assert property (
        wb_write_to(ccd_pkg::TH_LO_IDX) ##0 wb_sel_i[1]
        |=> detect_threshold[7:0] == $past(wb_dat_i[15:8]) && s_r.th_lo[7:0] == 8'h00)
        else $error("lower threshold byte not placed in bits 7 to 0");

    a_window_restart: assert property (
        ce_i && detect_mode_on && conv_valid_i && win_end |=> s_r.win_cnt == '0 && s_r.exc_cnt == '0)
        else $error("counts not restarted at the end of a window");

    a_flag_sticky: assert property (
        detect_pulse_o |-> detect_flag_o)
        else $error("detection pulse without the sticky flag");

endmodule : chop_current_detect_config

// >>> include/ccd_pkg.sv
package ccd_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] CFG_IDX    = 8'h06;
    localparam logic [7:0] TH_UP_IDX  = 8'h07;
    localparam logic [7:0] TH_LO_IDX  = 8'h08;
    localparam logic [7:0] STATUS_IDX = 8'h10;

    // Values after reset
    localparam logic [15:0] CFG_RST   = 16'h0600;
    localparam logic [15:0] TH_RST    = 16'h0000;
    localparam logic [3:0]  DLY_RST   = 4'h3;

    // Writable bits; low byte of the lower threshold register is outside this block
    localparam logic [15:0] CFG_WMASK   = 16'hffff;
    localparam logic [15:0] TH_LO_WMASK = 16'hff00;

    // Configuration field positions
    localparam int DLY_MSB  = 12;
    localparam int DLY_LSB  = 9;
    localparam int GC_BIT   = 8;
    localparam int ALL_BIT  = 7;
    localparam int NUM_MSB  = 6;
    localparam int NUM_LSB  = 4;
    localparam int LEN_MSB  = 3;
    localparam int LEN_LSB  = 1;
    localparam int EN_BIT   = 0;

    // Status register bits
    localparam int STAT_DETECT_BIT  = 0;
    localparam int STAT_SETTLED_BIT = 1;

    // Counter widths
    localparam int DLY_CNT_W = 17;
    localparam int EXC_CNT_W = 8;
    localparam int WIN_CNT_W = 12;

    // Settling delay: two to the power of code plus one modulator clocks
    function automatic logic [DLY_CNT_W-1:0] settle_cycles(input logic [3:0] code);
        settle_cycles = DLY_CNT_W'(17'h00002) << code;
    endfunction : settle_cycles

    // Threshold exceedances needed: two to the power of code
    function automatic logic [EXC_CNT_W:0] exceed_needed(input logic [2:0] code);
        exceed_needed = 9'h001 << code;
    endfunction : exceed_needed

    // Measurement window in conversion periods
    function automatic logic [WIN_CNT_W:0] window_len(input logic [2:0] code);
        case (code)
            3'h0:    window_len = 13'h0080;
            3'h1:    window_len = 13'h0100;
            3'h2:    window_len = 13'h0200;
            3'h3:    window_len = 13'h0300;
            3'h4:    window_len = 13'h0500;
            3'h5:    window_len = 13'h0700;
            3'h6:    window_len = 13'h0a00;
            default: window_len = 13'h0e00;
        endcase
    endfunction : window_len

endpackage : ccd_pkg

// >>> core/chop_settle_timer.sv
`timescale 1ns/100ps
module chop_settle_timer (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Control
    input  wire logic       run_i,
    input  wire logic       start_i,
    input  wire logic [3:0] sel_i,
    // Status
    output logic            settled_o
);

    typedef struct packed {
        logic [ccd_pkg::DLY_CNT_W-1:0] cnt;
        logic                          busy;
        logic                          settled;
    } timer_state_t;

    timer_state_t s_r;
    timer_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!run_i) begin
            s_nxt.busy    = 1'b0;
            s_nxt.settled = 1'b0;
        end else if (start_i) begin
            s_nxt.cnt     = ccd_pkg::settle_cycles(sel_i) - 17'h00001;
            s_nxt.busy    = 1'b1;
            s_nxt.settled = 1'b0;
        end else if (s_r.busy) begin
            if (s_r.cnt == '0) begin
                s_nxt.busy    = 1'b0;
                s_nxt.settled = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 17'h00001;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign settled_o = s_r.settled;

    // Elapsed enabled cycles since the last start, for checking only
    logic [ccd_pkg::DLY_CNT_W-1:0] elapsed_r;
    logic [3:0]                    sel_seen_r;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            elapsed_r  <= '0;
            sel_seen_r <= '0;
        end else if (ce_i) begin
            if (run_i && start_i) begin
                elapsed_r  <= '0;
                sel_seen_r <= sel_i;
            end else if (s_r.busy) begin
                elapsed_r <= elapsed_r + 17'h00001;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_settle_delay_exact: assert property (
        $rose(s_r.settled) |-> elapsed_r == ccd_pkg::settle_cycles(sel_seen_r))
        else $error("settling delay does not match the selected code");

    a_settle_off_run: assert property (
        ce_i && !run_i |=> !s_r.settled && !s_r.busy)
        else $error("settling timer active with global chop off");

endmodule : chop_settle_timer

// >>> testbench/chop_current_detect_config_tb.sv
`timescale 1ns/100ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value at %0t: %s", $time, m); end end
module chop_current_detect_config_tb;
    localparam int NCH = 8;
    typedef struct {logic [7:0] idx; logic [3:0] sel; logic [15:0] wd; logic [15:0] ex;} row_t;
    logic              clk_sys_i;
    logic              rst_i;
    logic              ce_i;
    logic              wb_cyc_i;
    logic              wb_stb_i;
    logic              wb_we_i;
    logic [31:0]       wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [31:0]       wb_dat_i;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic              conv_valid_i;
    logic [NCH*24-1:0] conv_data_i;
    logic              chop_start_i;
    logic              global_chop_on_o;
    logic              chop_settled_o;
    logic              detect_flag_o;
    logic              detect_pulse_o;
    int                error_cnt;
    int                total_checks;
    logic [15:0]       rd;
    logic              p;
    int                n;
    int                wl[8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};
    row_t              rows[6] = '{
        '{ccd_pkg::CFG_IDX, 4'h3, 16'ha5a5, 16'ha5a5},
        '{ccd_pkg::CFG_IDX, 4'h1, 16'h0000, 16'ha500},
        '{ccd_pkg::TH_UP_IDX, 4'h3, 16'h1234, 16'h1234},
        '{ccd_pkg::TH_LO_IDX, 4'h3, 16'habcd, 16'hab00},
        '{8'h3f, 4'h3, 16'hffff, 16'h0000},
        '{ccd_pkg::TH_LO_IDX, 4'h2, 16'h5600, 16'h5600}};

    chop_current_detect_config #(.NCH(NCH)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i), .chop_start_i(chop_start_i),
        .global_chop_on_o(global_chop_on_o), .chop_settled_o(chop_settled_o),
        .detect_flag_o(detect_flag_o), .detect_pulse_o(detect_pulse_o));

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // Entered right after a rising edge; ack and data are taken at the edge that sees ack
    task automatic wb(input logic we, input logic [7:0] idx, input logic [3:0] sel,
                      input logic [15:0] wd, output logic [15:0] q);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {22'h0, idx, 2'h0};
        wb_sel_i <= sel;
        wb_dat_i <= {16'h0000, wd};
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (wb_ack_o !== 1'b1) begin
            error_cnt++;
            summarize();
        end
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wb

    // Channel 0 gets d0, every other channel dr; returns the pulse seen one cycle later
    task automatic conv(input logic [23:0] d0, input logic [23:0] dr, output logic q);
        conv_valid_i <= 1'b1;
        conv_data_i  <= {{(NCH-1){dr}}, d0};
        @(posedge clk_sys_i);
        conv_valid_i <= 1'b0;
        @(posedge clk_sys_i);
        q = detect_pulse_o;
    endtask : conv

    // Disabling first clears the window and exceed counts
    task automatic arm(input logic [15:0] cfg);
        wb(1'b1, ccd_pkg::CFG_IDX, 4'h3, cfg & 16'hfffe, rd);
        wb(1'b1, ccd_pkg::CFG_IDX, 4'h3, cfg, rd);
    endtask : arm

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : do_reset

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        error_cnt = 0;
        total_checks = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, conv_valid_i, chop_start_i} = 5'h00;
        wb_adr_i = 32'h00000000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        conv_data_i = '0;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        wb(1'b0, ccd_pkg::CFG_IDX, 4'h3, 16'h0000, rd);
        `CHK(rd, 16'h0600, "config after reset")
        foreach (rows[i]) begin
            wb(1'b1, rows[i].idx, rows[i].sel, rows[i].wd, rd);
            wb(1'b0, rows[i].idx, 4'h3, 16'h0000, rd);
            `CHK(rd, rows[i].ex, "register readback")
        end
        $display("register table test done");
        do_reset();
        wb(1'b0, ccd_pkg::CFG_IDX, 4'h3, 16'h0000, rd);
        `CHK(rd, 16'h0600, "config after second reset")
        wb(1'b0, ccd_pkg::TH_UP_IDX, 4'h3, 16'h0000, rd);
        `CHK(rd, 16'h0000, "threshold after reset")
        $display("mid-run reset test done");
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, ccd_pkg::CFG_IDX, 4'h3, 16'h0100 | (16'(c) << 9), rd);
            @(posedge clk_sys_i);
            `CHK(global_chop_on_o, 1'b1, "chop enable output")
            chop_start_i <= 1'b1;
            @(posedge clk_sys_i);
            chop_start_i <= 1'b0;
            n = 0;
            do begin
                @(posedge clk_sys_i);
                n++;
            end while (chop_settled_o !== 1'b1 && n < 100);
            `CHK(n, (2 << c) + 1, "settling delay length")
            wb(1'b0, ccd_pkg::STATUS_IDX, 4'h3, 16'h0000, rd);
            `CHK(rd, 16'h0002, "status shows settled")
        end
        wb(1'b1, ccd_pkg::CFG_IDX, 4'h3, 16'h0000, rd);
        @(posedge clk_sys_i);
        `CHK({global_chop_on_o, chop_settled_o}, 2'b00, "chop off")
        $display("chop settling test done");
        // Threshold 0x80 needs the lower register; negative data must not count as over
        wb(1'b1, ccd_pkg::TH_LO_IDX, 4'h3, 16'h8000, rd);
        wb(1'b1, ccd_pkg::CFG_IDX, 4'h3, 16'h0000, rd);
        conv(24'h000081, 24'h800000, p);
        `CHK(p, 1'b0, "detect while disabled")
        arm(16'h0011);
        conv(24'h000080, 24'h800000, p);
        conv(24'h000081, 24'h800000, p);
        `CHK(p, 1'b0, "equal value is not over")
        conv(24'h000081, 24'h800000, p);
        `CHK({p, detect_flag_o}, 2'b11, "second exceed detects")
        wb(1'b0, ccd_pkg::STATUS_IDX, 4'h3, 16'h0000, rd);
        `CHK(rd, 16'h0001, "status shows detection")
        wb(1'b1, ccd_pkg::STATUS_IDX, 4'h3, 16'h0001, rd);
        `CHK(detect_flag_o, 1'b0, "flag cleared")
        arm(16'h0081);
        conv(24'h000081, 24'h800000, p);
        `CHK(p, 1'b0, "all mode one channel")
        conv(24'h000081, 24'h000081, p);
        `CHK(p, 1'b1, "all mode every channel")
        arm(16'h0081);
        ce_i <= 1'b0;
        conv(24'h000081, 24'h000081, p);
        `CHK(p, 1'b0, "frozen while clock enable low")
        ce_i <= 1'b1;
        conv(24'h000081, 24'h000081, p);
        `CHK(p, 1'b1, "detects once enable returns")
        $display("detect mode test done");
        for (int c = 0; c < 8; c++) begin
            arm(16'h0003 | (16'(c) << 4));
            for (int k = 1; k < (1 << c); k++) begin
                conv(24'h000081, 24'h000000, p);
                `CHK(p, 1'b0, "too few exceeds")
            end
            conv(24'h000081, 24'h000000, p);
            `CHK(p, 1'b1, "exceed count reached")
        end
        $display("exceed count test done");
        for (int c = 0; c < 8; c++) begin
            for (int g = 0; g < 2; g++) begin
                arm(16'h0011 | (16'(c) << 1));
                conv(24'h000081, 24'h000000, p);
                repeat (wl[c] - 2 + g) conv(24'h000000, 24'h000000, p);
                conv(24'h000081, 24'h000000, p);
                `CHK(p, g == 0, "window length")
            end
        end
        $display("window length test done");
        summarize();
    end
endmodule : chop_current_detect_config_tb
